/* File: verilog/line_self_bus_regs.sv */
// Purpose: line status, self control/status and bus control/status registers
// Assumes: receiver, eeprom engine and bus front end run on ref_clk
// Notes:   sleep and rom serial-in pins are synchronised here
`timescale 1ns/10ps

// Functional notes
// - low six bits always read register identifier
// - link_alive clears after reset or 50 ms silence
// - bits 8/9 flag active attachment port
// - polarity bit shows truth; fix unless disabled
// - carrier drops about two bits after data
// - reset bit starts chip reset, self clears
// - soft suspend resets line, bus and dma logic; self control, rom status, power and led outputs kept
// - any io write in space leaves suspend
// - enabled sleep pin selects standby or suspend
// - host bits drive gpo pins, inverted level
// - reset values 0015 and 0017, rom may load
// - init_done after init; pnp_off from rom
// - rom busy mirrors chip select; host waits
// - rom detect strap, checksum, size flags
// - dma clear bit terminates, flushes, zeroes once
// - mcs16 on high address match, optionally low
// - memory mode gated, io always enabled
// - burst limit 28 us then 1.3 us gap
// - wait-state pin only on read cycles
// - buffer size select and interrupt gate
// - bid reject on oversize frame, not short
// - tx space is a pollable level
// - no link and no override blocks packets
module line_self_bus_regs
  import line_self_bus_pkg::*;
#(
  parameter int LINK_FAIL_CYCLES = LINK_FAIL_CYC
) (
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // register port
  input  wire line_self_bus_pkg::reg_req_t reg_req,
  input  wire logic                        io_write_hit,
  output logic [15:0]                      reg_rdata,
  output logic                             reg_rvalid,
  // receiver and line
  input  wire logic                        link_activity,
  input  wire logic                        link_test_off,
  input  wire logic                        aui_active,
  input  wire logic                        rx_pol_normal,
  input  wire logic                        polarity_fix_disable,
  input  wire logic                        rx_frame,
  input  wire logic                        rx_data_rec,
  output logic                             rx_pol_invert,
  output logic                             pkt_enable,
  output logic                             link_pulses_only,
  // chip power and reset
  input  wire logic                        sleep_pin_n,
  output logic                             chip_reset_out,
  output logic                             part_reset_out,
  output logic                             hw_standby,
  output logic                             hw_suspend,
  // leds and host outputs
  input  wire logic                        rx_bus_activity,
  output logic                             gpo0_pin,
  output logic                             gpo1_pin,
  // eeprom
  input  wire logic                        rom_serial_in,
  input  wire logic                        rom_chip_select,
  input  wire logic                        rom_load_valid,
  input  wire logic [15:0]                 rom_self_ctl,
  input  wire logic [15:0]                 rom_bus_ctl,
  input  wire logic                        rom_done,
  input  wire logic                        rom_csum_ok,
  input  wire logic                        rom_size64,
  input  wire logic                        rom_pnp_off,
  // isa side
  input  wire logic [6:0]                  la_addr,
  input  wire logic [3:0]                  sa_addr,
  input  wire logic [6:0]                  mem_base_hi,
  input  wire logic [3:0]                  mem_base_lo,
  input  wire logic                        mem_cycle,
  input  wire logic                        io_rd_cycle,
  input  wire logic                        mem_rd_cycle,
  input  wire logic                        need_wait,
  output logic                             mcs16_n,
  output logic                             mem_space_en,
  output logic                             iochrdy_o,
  output logic                             iochrdy_oe,
  // receive dma
  input  wire logic                        rx_dma_want,
  output logic                             rx_dma_req,
  output logic                             rx_dma_ptr_clear,
  output logic                             rx_dma_buf_large,
  output logic                             irq_gate,
  // transmit bid
  input  wire logic                        tx_bid_valid,
  input  wire logic [10:0]                 tx_bid_len,
  input  wire logic                        crc_insert_off,
  input  wire logic                        tx_space_in
);

  // ==========================================================
  // helpers
  // address hit on a register write or read
  function automatic logic hit(input logic [9:0] a, input logic [9:0] off);
    return a == off;
  endfunction

  // place a six-bit identifier under the status bits
  function automatic logic [15:0] with_id(input logic [15:0] v, input logic [5:0] id);
    return {v[15:6], id};
  endfunction

  // ==========================================================
  // state
  logic        chip_rst_r;            // pending chip-wide reset, one cycle
  logic        any_rst;               // hard or chip reset
  logic        part_rst;              // any reset or suspend
  logic [15:0] self_ctl_r;            // stored control bits only
  logic [15:0] bus_ctl_r;
  logic        sleep_s1_r;            // sleep pin synchroniser
  logic        sleep_s2_r;
  logic        rom_s1_r;              // rom serial-in synchroniser
  logic        rom_s2_r;
  logic        strap_done_r;          // rom presence captured
  logic        rom_det_r;
  logic        init_done_r;
  logic        csum_r;
  logic        small_r;
  logic        pnp_off_r;
  logic        rom_busy_r;
  logic        link_alive_r;
  logic [31:0] link_cnt_r;
  logic        crs_r;
  logic [7:0]  crs_cnt_r;
  logic        data_d_r;
  logic        pol_r;
  logic        aui_r;
  logic        bid_rej_r;
  logic        tx_space_r;
  logic [10:0] dma_cnt_r;
  logic        dma_gap_r;
  logic        suspend;
  logic        wr_self;
  logic        wr_bus;
  logic        bid_bad;

  // any reset returns the self control bits; suspend does not
  assign any_rst  = rst | chip_rst_r;
  assign suspend  = self_ctl_r[B_SUSPEND];
  assign part_rst = any_rst | suspend;
  assign wr_self  = reg_req.wr & hit(reg_req.addr, OFF_SELF_CTL);
  assign wr_bus   = reg_req.wr & hit(reg_req.addr, OFF_BUS_CTL);
  // crc appended by device needs four bytes of headroom
  assign bid_bad  = crc_insert_off ? (tx_bid_len > 11'(MAX_LEN_RAW))
                                   : (tx_bid_len > 11'(MAX_LEN_CRC));

  // ==========================================================
  // chip reset request: the bit lives one cycle, the reset it starts clears it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      chip_rst_r <= 1'b0;
    end else if (chip_rst_r) begin
      chip_rst_r <= 1'b0;
    end else begin
      chip_rst_r <= wr_self & reg_req.wdata[B_CHIP_RST];
    end
  end

  // ==========================================================
  // self control register
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      self_ctl_r <= RST_SELF_CTL & MASK_SELF_CTL;
    end else if (wr_self) begin
      // only defined bits are kept; identifier ignored
      self_ctl_r <= reg_req.wdata & MASK_SELF_CTL & ~(16'h0001 << B_CHIP_RST);
    end else if (suspend && io_write_hit) begin
      self_ctl_r[B_SUSPEND] <= 1'b0;
    end else if (rom_load_valid && rom_det_r) begin
      self_ctl_r <= rom_self_ctl & MASK_SELF_CTL & ~(16'h0001 << B_CHIP_RST);
    end
  end

  // ==========================================================
  // bus control register; dma clear bit is act-once
  always_ff @(posedge ref_clk) begin
    if (part_rst) begin
      bus_ctl_r <= RST_BUS_CTL & MASK_BUS_CTL;
    end else if (wr_bus) begin
      bus_ctl_r <= reg_req.wdata & MASK_BUS_CTL;
    end else if (rom_load_valid && rom_det_r) begin
      bus_ctl_r <= rom_bus_ctl & MASK_BUS_CTL & ~(16'h0001 << B_DMA_CLR);
    end else begin
      bus_ctl_r[B_DMA_CLR] <= 1'b0;
    end
  end

  // dma clear pulse: one cycle per written one
  always_ff @(posedge ref_clk) begin
    if (part_rst) begin
      rx_dma_ptr_clear <= 1'b0;
    end else begin
      rx_dma_ptr_clear <= wr_bus & reg_req.wdata[B_DMA_CLR];
    end
  end

  // ==========================================================
  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge ref_clk) begin
    rom_s1_r <= rom_serial_in;
    rom_s2_r <= rom_s1_r;
    if (rst) begin
      sleep_s1_r <= 1'b1;
      sleep_s2_r <= 1'b1;
    end else begin
      sleep_s1_r <= sleep_pin_n;
      sleep_s2_r <= sleep_s1_r;
    end
  end

  // ==========================================================
  // eeprom strap and status; strap caught once after release
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      strap_done_r <= 1'b0;
      rom_det_r    <= 1'b0;
      init_done_r  <= 1'b0;
      csum_r       <= 1'b0;
      small_r      <= 1'b0;
      pnp_off_r    <= 1'b0;
    end else if (!strap_done_r) begin
      // unreset rom synchroniser already holds the pin
      strap_done_r <= 1'b1;
      rom_det_r    <= rom_s2_r;
    end else if (!init_done_r) begin
      if (!rom_det_r) begin
        init_done_r <= 1'b1;
      end else if (rom_done) begin
        init_done_r <= 1'b1;
        csum_r      <= rom_csum_ok;
        small_r     <= rom_size64;
        pnp_off_r   <= rom_pnp_off;
      end
    end
  end

  // busy flag follows the chip select output
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rom_busy_r <= 1'b0;
    end else begin
      rom_busy_r <= rom_chip_select;
    end
  end

  // ==========================================================
  // link integrity timer; activity restarts the count
  always_ff @(posedge ref_clk) begin
    if (part_rst) begin
      link_alive_r <= 1'b0;
      link_cnt_r   <= '0;
    end else if (link_activity) begin
      link_alive_r <= 1'b1;
      link_cnt_r   <= '0;
    end else if (link_cnt_r >= 32'(LINK_FAIL_CYCLES - 1)) begin
      link_alive_r <= 1'b0;
    end else begin
      link_cnt_r   <= link_cnt_r + 32'd1;
    end
  end

  // ==========================================================
  // carrier sense: hold after the last rising edge of recovered data
  always_ff @(posedge ref_clk) begin
    if (part_rst) begin
      crs_r     <= 1'b0;
      crs_cnt_r <= '0;
      data_d_r  <= 1'b0;
    end else begin
      data_d_r <= rx_data_rec;
      if (rx_data_rec && !data_d_r) begin
        crs_cnt_r <= 8'(CRS_DROP_CYC);
      end else if (crs_cnt_r != 8'h00) begin
        crs_cnt_r <= crs_cnt_r - 8'h01;
      end
      // frame start raises carrier, count expiry after frame ends drops it
      if (rx_frame) begin
        crs_r <= 1'b1;
      end else if (crs_cnt_r <= 8'h01 && !(rx_data_rec && !data_d_r)) begin
        crs_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // line state, polarity and link gating
  always_ff @(posedge ref_clk) begin
    if (part_rst) begin
      pol_r            <= 1'b1;
      aui_r            <= 1'b0;
      rx_pol_invert    <= 1'b0;
      pkt_enable       <= 1'b0;
      link_pulses_only <= 1'b0;
    end else begin
      pol_r            <= rx_pol_normal;
      aui_r            <= aui_active;
      rx_pol_invert    <= !rx_pol_normal && !polarity_fix_disable;
      pkt_enable       <= link_alive_r || link_test_off || aui_active;
      link_pulses_only <= !aui_active && !link_alive_r && !link_test_off;
    end
  end

  // ==========================================================
  // power modes and reset outputs
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      hw_standby     <= 1'b0;
      hw_suspend     <= 1'b0;
      part_reset_out <= 1'b0;
    end else begin
      hw_standby     <= self_ctl_r[B_SLEEP_EN] && !sleep_s2_r && self_ctl_r[B_STANDBY];
      hw_suspend     <= self_ctl_r[B_SLEEP_EN] && !sleep_s2_r && !self_ctl_r[B_STANDBY];
      part_reset_out <= suspend && !(io_write_hit);
    end
  end

  // chip reset output mirrors the pending request, also on hard reset
  always_ff @(posedge ref_clk) begin
    chip_reset_out <= any_rst;
  end

  // ==========================================================
  // led pins; host level is active low on the pin
  always_ff @(posedge ref_clk) begin
    if (any_rst) begin
      gpo0_pin <= 1'b1;
      gpo1_pin <= 1'b1;
    end else begin
      gpo0_pin <= self_ctl_r[B_GPO0_SEL] ? !self_ctl_r[B_GPO0_LVL] : !link_alive_r;
      gpo1_pin <= self_ctl_r[B_GPO1_SEL] ? !self_ctl_r[B_GPO1_LVL] : !rx_bus_activity;
    end
  end

  // ==========================================================
  // isa decode: memory chip select and wait states
  always_ff @(posedge ref_clk) begin
    if (part_rst) begin
      mcs16_n          <= 1'b1;
      mem_space_en     <= 1'b0;
      iochrdy_o        <= 1'b0;
      iochrdy_oe       <= 1'b0;
      rx_dma_buf_large <= 1'b0;
      irq_gate         <= 1'b0;
    end else begin
      mcs16_n <= !(bus_ctl_r[B_MEM_EN] && la_addr == mem_base_hi &&
                   (!bus_ctl_r[B_MATCH_LOW] || sa_addr == mem_base_lo));
      // io mode needs no enable; memory cycles are gated here only
      mem_space_en     <= bus_ctl_r[B_MEM_EN];
      iochrdy_o        <= 1'b0;
      iochrdy_oe       <= !bus_ctl_r[B_WAIT_OFF] && need_wait &&
                          (io_rd_cycle || (mem_rd_cycle && mem_cycle && bus_ctl_r[B_MEM_EN]));
      rx_dma_buf_large <= bus_ctl_r[B_BUF_LARGE];
      irq_gate         <= bus_ctl_r[B_IRQ_GATE];
    end
  end

  // ==========================================================
  // receive dma burst limiter; a clear aborts the burst
  always_ff @(posedge ref_clk) begin
    if (part_rst || rx_dma_ptr_clear) begin
      dma_cnt_r  <= '0;
      dma_gap_r  <= 1'b0;
      rx_dma_req <= 1'b0;
    end else if (dma_gap_r) begin
      rx_dma_req <= 1'b0;
      if (dma_cnt_r >= 11'(GAP_CYC - 1)) begin
        dma_gap_r <= 1'b0;
        dma_cnt_r <= '0;
      end else begin
        dma_cnt_r <= dma_cnt_r + 11'd1;
      end
    end else if (rx_dma_want) begin
      if (bus_ctl_r[B_BURST_LIM] && dma_cnt_r >= 11'(BURST_CYC - 1)) begin
        dma_gap_r  <= 1'b1;
        dma_cnt_r  <= '0;
        rx_dma_req <= 1'b0;
      end else begin
        rx_dma_req <= 1'b1;
        dma_cnt_r  <= dma_cnt_r + 11'd1;
      end
    end else begin
      rx_dma_req <= 1'b0;
      dma_cnt_r  <= '0;
    end
  end

  // ==========================================================
  // transmit bid status; a new acceptable bid clears the error
  always_ff @(posedge ref_clk) begin
    if (part_rst) begin
      bid_rej_r  <= 1'b0;
      tx_space_r <= 1'b0;
    end else begin
      tx_space_r <= tx_space_in;
      if (tx_bid_valid) begin
        bid_rej_r <= bid_bad;
      end
    end
  end

  // ==========================================================
  // read mux; answer one cycle after the read strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      reg_rdata  <= 16'h0000;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_req.rd;
      if (!reg_req.rd) begin
        reg_rdata <= reg_rdata;
      end else if (hit(reg_req.addr, OFF_LINE_ST)) begin
        reg_rdata <= with_id({1'b0, crs_r, 1'b0, pol_r, 2'b00, !aui_r, aui_r,
                              link_alive_r, 7'h00}, ID_LINE_ST);
      end else if (hit(reg_req.addr, OFF_SELF_CTL)) begin
        reg_rdata <= with_id(self_ctl_r | (16'(chip_rst_r) << B_CHIP_RST), ID_SELF_CTL);
      end else if (hit(reg_req.addr, OFF_SELF_ST)) begin
        reg_rdata <= with_id({3'b000, small_r, 1'b0, csum_r, rom_det_r, rom_busy_r,
                              init_done_r, pnp_off_r, 6'h00}, ID_SELF_ST);
      end else if (hit(reg_req.addr, OFF_BUS_CTL)) begin
        reg_rdata <= with_id(bus_ctl_r, ID_BUS_CTL);
      end else if (hit(reg_req.addr, OFF_BUS_ST)) begin
        reg_rdata <= with_id({7'h00, tx_space_r, bid_rej_r, 7'h00}, ID_BUS_ST);
      end else begin
        reg_rdata <= 16'h0000;
      end
    end
  end

endmodule

/* File: pkg/line_self_bus_pkg.sv */
// Purpose: shared constants and types for the line/self/bus control-status bank
// Assumes: 16-bit registers reached over the chip's internal register port
// Notes:   all timing counts derive from the 50 MHz reference clock
package line_self_bus_pkg;

  // ==========================================================
  // register offsets and identifiers
  localparam logic [9:0] OFF_SELF_CTL = 10'h114;
  localparam logic [9:0] OFF_BUS_CTL  = 10'h116;
  localparam logic [9:0] OFF_LINE_ST  = 10'h134;
  localparam logic [9:0] OFF_SELF_ST  = 10'h136;
  localparam logic [9:0] OFF_BUS_ST   = 10'h138;

  localparam logic [5:0] ID_LINE_ST   = 6'h14;
  localparam logic [5:0] ID_SELF_CTL  = 6'h15;
  localparam logic [5:0] ID_SELF_ST   = 6'h16;
  localparam logic [5:0] ID_BUS_CTL   = 6'h17;
  localparam logic [5:0] ID_BUS_ST    = 6'h18;

  // ==========================================================
  // reset values and writable masks
  localparam logic [15:0] RST_SELF_CTL = 16'h0015;
  localparam logic [15:0] RST_BUS_CTL  = 16'h0017;
  localparam logic [15:0] MASK_SELF_CTL = 16'hf740;
  localparam logic [15:0] MASK_BUS_CTL  = 16'hbe40;

  // ==========================================================
  // field positions
  localparam int B_LINK_ALIVE = 7;
  localparam int B_AUI_ACT    = 8;
  localparam int B_TP_ACT     = 9;
  localparam int B_POL_GOOD   = 12;
  localparam int B_CRS        = 14;
  localparam int B_CHIP_RST   = 6;
  localparam int B_SUSPEND    = 8;
  localparam int B_SLEEP_EN   = 9;
  localparam int B_STANDBY    = 10;
  localparam int B_GPO0_SEL   = 12;
  localparam int B_GPO1_SEL   = 13;
  localparam int B_GPO0_LVL   = 14;
  localparam int B_GPO1_LVL   = 15;
  localparam int B_PNP_OFF    = 6;
  localparam int B_INIT_DONE  = 7;
  localparam int B_ROM_BUSY   = 8;
  localparam int B_ROM_DET    = 9;
  localparam int B_ROM_CSUM   = 10;
  localparam int B_ROM_SMALL  = 12;
  localparam int B_DMA_CLR    = 6;
  localparam int B_MATCH_LOW  = 9;
  localparam int B_MEM_EN     = 10;
  localparam int B_BURST_LIM  = 11;
  localparam int B_WAIT_OFF   = 12;
  localparam int B_BUF_LARGE  = 13;
  localparam int B_IRQ_GATE   = 15;
  localparam int B_BID_REJ    = 7;
  localparam int B_TX_SPACE   = 8;

  // ==========================================================
  // timing
  localparam int CLK_HZ        = 50_000_000;
  localparam int CLK_NS        = 20;
  localparam int LINK_FAIL_MS  = 50;
  localparam int LINK_FAIL_CYC = LINK_FAIL_MS * (CLK_HZ / 1000);
  localparam int BIT_NS        = 100;
  localparam int CRS_DROP_BX10 = 18;       // 1.8 bit times, inside 1.3..2.3
  localparam int CRS_DROP_CYC  = (CRS_DROP_BX10 * BIT_NS) / (10 * CLK_NS);
  localparam int BURST_NS      = 28_000;
  localparam int BURST_CYC     = BURST_NS / CLK_NS;          // longest: round down
  localparam int GAP_NS        = 1_300;
  localparam int GAP_CYC       = (GAP_NS + CLK_NS - 1) / CLK_NS; // least: round up
  localparam int MAX_LEN_CRC   = 1514;
  localparam int MAX_LEN_RAW   = 1518;

  // ==========================================================
  // register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [9:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

endpackage

/* File: test/isa_host_model.sv */
// Purpose: host-side model driving the register port of the bank
// Assumes: one access at a time, launched just after a clock edge
// Notes:   register writes leave the io-space hit low; wake() raises it
`timescale 1ns/10ps
module isa_host_model
  import line_self_bus_pkg::*;
(
  input  wire logic                   ref_clk,
  output line_self_bus_pkg::reg_req_t reg_req,
  output logic                        io_write_hit
);
  // ==========================================
  // idle bus at time zero
  initial begin
    reg_req = '0;
    io_write_hit = 1'b0;
  end
  // one strobe cycle; offsets 0x40/0x42 are never targeted here
  // released address and data flip so a stale value cannot pass
  task automatic acc(input logic w, input logic [9:0] a, input logic [15:0] d);
    @(posedge ref_clk) #1;
    reg_req = '{w, !w, a, d};
    @(posedge ref_clk) #1;
    reg_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
  // any io write inside the device space ends soft suspend
  task automatic wake;
    @(posedge ref_clk) #1;
    io_write_hit = 1'b1;
    @(posedge ref_clk) #1;
    io_write_hit = 1'b0;
  endtask
endmodule

/* File: test/line_self_bus_regs_chk.sv */
// Purpose: concurrent checks on the register bank ports
// Assumes: single ref_clk domain, synchronous active-high rst
// Notes:   bound into every instance of the bank
`timescale 1ns/10ps
module line_self_bus_regs_chk
  import line_self_bus_pkg::*;
(
  input wire logic                        ref_clk, rst, reg_rvalid, rx_pol_normal, polarity_fix_disable,
  input wire logic                        rx_pol_invert, link_activity, pkt_enable, io_rd_cycle, mem_rd_cycle,
  input wire logic                        iochrdy_oe, rx_dma_ptr_clear, chip_reset_out, part_reset_out,
  input wire logic                        mem_space_en, mcs16_n,
  input wire logic [15:0]                 reg_rdata,
  input wire line_self_bus_pkg::reg_req_t reg_req
);
  // ==========================================
  // one domain: clock and reset given once
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // writes carrying a set act-once bit
  wire clr_wr = reg_req.wr && reg_req.addr == OFF_BUS_CTL && reg_req.wdata[B_DMA_CLR];
  wire rst_wr = reg_req.wr && reg_req.addr == OFF_SELF_CTL && reg_req.wdata[B_CHIP_RST];
  chk_line_id: assert property (reg_req.rd && reg_req.addr == OFF_LINE_ST |=> reg_rvalid && reg_rdata[5:0] == ID_LINE_ST)
    else $error("line status read lacks its identifier");
  chk_bus_id: assert property (reg_req.rd && reg_req.addr == OFF_BUS_ST |=> reg_rdata[5:0] == ID_BUS_ST)
    else $error("bus status read lacks its identifier");
  chk_pol_cause: assert property (rx_pol_invert |-> $past(!rx_pol_normal && !polarity_fix_disable))
    else $error("polarity fix without reversed, enabled input");
  chk_link_pkt: assert property (link_activity && !part_reset_out |-> ##[1:2] pkt_enable)
    else $error("link activity did not enable packets");
  chk_wait_reads: assert property (!(io_rd_cycle || mem_rd_cycle) [*2] |-> !iochrdy_oe)
    else $error("wait state outside a read cycle");
  chk_clr_once: assert property (rx_dma_ptr_clear |=> !rx_dma_ptr_clear)
    else $error("dma clear longer than one cycle");
  chk_clr_cause: assert property (clr_wr && !part_reset_out |=> rx_dma_ptr_clear)
    else $error("dma clear write had no effect");
  chk_chip_rst: assert property (rst_wr |-> ##[1:2] chip_reset_out)
    else $error("chip reset bit did not reset");
  chk_mcs_off: assert property (!mem_space_en [*2] |-> mcs16_n)
    else $error("memory select with memory mode off");
  // main scenarios reached
  cover property (rx_dma_ptr_clear);
  cover property (chip_reset_out);
  cover property (part_reset_out);
endmodule
bind line_self_bus_regs line_self_bus_regs_chk chk (.*);

/* File: test/line_self_bus_regs_bench.sv */
// Purpose: self-checking bench for the register bank
// Assumes: host model issues every register access
// Notes:   reads queue their expected word; a monitor checks each answer
`timescale 1ns/10ps
module line_self_bus_regs_bench;
  import line_self_bus_pkg::*;
  // ==========================================
  // pins set by tests, then a block shuffled each cycle
  logic ref_clk = 0, rst = 1, link_activity = 0, aui_active = 0, rx_pol_normal = 0, rx_frame = 0;
  logic rx_data_rec = 0, rom_serial_in = 0, rom_load_valid = 0, rom_done = 0, rom_chip_select = 0;
  logic tx_bid_valid = 0, crc_insert_off = 0, tx_space_in = 0, link_test_off, polarity_fix_disable;
  logic sleep_pin_n, rx_bus_activity, mem_cycle, io_rd_cycle, mem_rd_cycle, need_wait, rx_dma_want;
  logic rom_csum_ok, rom_size64, rom_pnp_off, io_write_hit, reg_rvalid, rx_pol_invert, pkt_enable;
  logic link_pulses_only, chip_reset_out, part_reset_out, hw_standby, hw_suspend, gpo0_pin, gpo1_pin;
  logic mcs16_n, mem_space_en, iochrdy_o, iochrdy_oe, rx_dma_req, rx_dma_ptr_clear, rx_dma_buf_large, irq_gate;
  logic [6:0]  la_addr, mem_base_hi;
  logic [3:0]  sa_addr, mem_base_lo;
  logic [15:0] rom_self_ctl, rom_bus_ctl, w, reg_rdata;
  logic [10:0] tx_bid_len = 11'h000;
  logic [10:0] blen [5] = '{11'h5eb, 11'h5ea, 11'h5ee, 11'h5ef, 11'h028}; // bid lengths
  logic [4:0]  bcrc = 5'h0c, bexp = 5'h09; // crc-off and reject flags by index
  reg_req_t    reg_req;
  logic [15:0] expq [$]; // expected read words, oldest first
  int          n_fail = 0, n_tests = 0;
  line_self_bus_regs #(.LINK_FAIL_CYCLES(200)) DUT (.*);
  isa_host_model host (.ref_clk(ref_clk), .reg_req(reg_req), .io_write_hit(io_write_hit));
  initial forever #10 ref_clk = ~ref_clk;
  // ==========================================
  // inputs no expectation depends on, reshuffled just after each edge
  task automatic rnd;
    {la_addr, mem_base_hi, sa_addr, mem_base_lo, mem_cycle, io_rd_cycle, mem_rd_cycle, need_wait, rx_dma_want,
     rx_bus_activity, sleep_pin_n, link_test_off, polarity_fix_disable, rom_csum_ok, rom_size64, rom_pnp_off,
     rom_self_ctl, rom_bus_ctl} = 66'({$urandom, $urandom, $urandom});
  endtask
  always @(posedge ref_clk) #1 rnd();
  task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // monitor: every answer takes the oldest note
  always @(posedge ref_clk) if (reg_rvalid === 1'b1) cmp("read data", expq.pop_front(), reg_rdata);
  task automatic rd(logic [9:0] a, logic [15:0] e);
    expq.push_back(e);
    host.acc(1'b0, a, 16'h0000);
  endtask
  task automatic tend(string s);
    $display("test %s done, failures %0d", s, n_fail);
  endtask
  task automatic results;
    $display("comparisons %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ==========================================
  // main sequence
  initial begin
    void'($urandom(72));
    rnd();
    repeat (12) @(posedge ref_clk);
    #1 rst = 0;
    repeat (4) @(posedge ref_clk);
    #1 rom_chip_select = 1;
    tx_space_in = 1;
    rd(OFF_SELF_CTL, RST_SELF_CTL);
    rd(OFF_BUS_CTL, RST_BUS_CTL);
    rd(OFF_SELF_ST, 16'h0196);
    host.acc(1'b1, OFF_BUS_ST, 16'hffff);
    rd(OFF_BUS_ST, 16'h0118);
    rd(10'h100, 16'h0000);
    tend("reset and read-only");
    repeat (4) begin
      w = 16'($urandom) | 16'h3000;
      host.acc(1'b1, OFF_SELF_CTL, w & 16'hfcbf);
      host.acc(1'b1, OFF_BUS_CTL, w & 16'hffbf);
      rd(OFF_SELF_CTL, w & 16'hf400 | 16'h0015);
      rd(OFF_BUS_CTL, w & 16'hbe00 | 16'h0017);
      cmp("pins", {~w[15:14], 2'b00}, {gpo1_pin, gpo0_pin, hw_standby, hw_suspend});
      cmp("bus levels", {w[15], w[13], w[10]}, {irq_gate, rx_dma_buf_large, mem_space_en});
    end
    tend("control words");
    rx_pol_normal = 1;
    @(posedge ref_clk) #1 {link_activity, rx_frame} = 2'b11;
    @(posedge ref_clk) #1 link_activity = 0;
    rd(OFF_LINE_ST, 16'h5294);
    rx_frame = 0;
    repeat (210) @(posedge ref_clk);
    rd(OFF_LINE_ST, 16'h1214);
    aui_active = 1;
    rx_pol_normal = 0;
    rd(OFF_LINE_ST, 16'h0114);
    tend("line status");
    for (int i = 0; i < 5; i++) begin
      crc_insert_off = bcrc[i];
      @(posedge ref_clk) #1 {tx_bid_valid, tx_bid_len} = {1'b1, blen[i]};
      @(posedge ref_clk) #1 tx_bid_valid = 0;
      rd(OFF_BUS_ST, {8'h01, bexp[i], 7'h18});
    end
    tend("transmit bids");
    host.acc(1'b1, OFF_BUS_CTL, 16'h0040);
    rd(OFF_BUS_CTL, RST_BUS_CTL);
    host.acc(1'b1, OFF_BUS_CTL, 16'h8000);
    rom_serial_in = 1;
    host.acc(1'b1, OFF_SELF_CTL, 16'h0040);
    repeat (4) @(posedge ref_clk);
    rd(OFF_BUS_CTL, RST_BUS_CTL);
    rd(OFF_SELF_ST, 16'h0316);
    host.acc(1'b1, OFF_BUS_CTL, 16'h8000);
    host.acc(1'b1, OFF_SELF_CTL, 16'h0100);
    rd(OFF_BUS_CTL, RST_BUS_CTL);
    rd(OFF_SELF_CTL, 16'h0115);
    host.wake();
    host.acc(1'b1, OFF_BUS_CTL, 16'h8000);
    rd(OFF_BUS_CTL, 16'h8017);
    repeat (3) @(posedge ref_clk);
    tend("act-once and suspend");
    results();
  end
  // watchdog: the run needs under 2000 cycles
  initial begin
    #200_000;
    n_fail++;
    results();
  end
endmodule
